// *** hdl/sadc_readout.sv ***
// Device end of the serial converter: pin sync, framing, hold and shift-out
`include "sadc_cfg.svh"

module sadc_readout (
  input wire logic clk, // 20 MHz system clock
  input wire logic rst, // Async reset, active high
  input wire logic sel_n, // Chip select pin, active low
  input wire logic shift_clk, // Shift clock pin from host
  input wire logic shared_serial_line_i, // Level seen on data line
  output logic shared_serial_line_o, // Level driven on data line
  output logic shared_serial_line_oe, // High while driving data line
  input wire logic [`SADC_IN_W-1:0] ain0, // First analogue input, digitised level
  input wire logic [`SADC_IN_W-1:0] ain1, // Second analogue input, digitised level
  input wire logic [`SADC_IN_W-1:0] vref, // Reference level
  output logic busy, // Transaction in progress
  output logic [`SADC_CODE_W-1:0] result_code // Last code shifted out
);
  // Pins: cs, clock, data into one vector for the synchroniser
  logic [2:0] pin_s1_reg;
  logic [2:0] pin_s2_reg;
  logic [2:0] pin_s3_reg;
  logic [2:0] pin_filt_reg;
  logic [2:0] pin_filt_next;
  logic clk_prev_reg;
  logic clk_rise;
  logic clk_fall;
  logic cs_act;
  logic din;

  sadc_pkg::sadc_state_e state_reg;
  sadc_pkg::sadc_setup_s setup_reg;
  sadc_pkg::sadc_held_s held_reg;
  logic [1:0] setup_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic line_o_reg;
  logic line_oe_reg;
  logic busy_reg;
  logic [`SADC_CODE_W-1:0] result_reg;

  logic [`SADC_IN_W-1:0] pick_pos;
  logic [`SADC_IN_W-1:0] pick_neg;
  logic [`SADC_IN_W-1:0] held_diff;
  logic [`SADC_IN_W+`SADC_STEP_SH-1:0] scaled;
  logic [`SADC_IN_W+`SADC_STEP_SH-1:0] quot;
  logic [`SADC_CODE_W-1:0] code;
  logic capture;

  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_reg <= `SADC_PIN_IDLE;
      pin_s2_reg <= `SADC_PIN_IDLE;
      pin_s3_reg <= `SADC_PIN_IDLE;
    end else begin
      pin_s1_reg <= {shared_serial_line_i, shift_clk, sel_n};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  always_comb begin
    pin_filt_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg))
                  | (pin_filt_reg & (pin_s2_reg ^ pin_s3_reg));
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_filt_reg <= `SADC_PIN_IDLE;
      clk_prev_reg <= 1'b0;
    end else begin
      pin_filt_reg <= pin_filt_next;
      clk_prev_reg <= pin_filt_reg[`SADC_PIN_CLK];
    end
  end

  assign cs_act = ~pin_filt_reg[`SADC_PIN_CS]; // RULE1
  assign din = pin_filt_reg[`SADC_PIN_DAT];
  assign clk_rise = pin_filt_reg[`SADC_PIN_CLK] & ~clk_prev_reg; // RULE2
  assign clk_fall = ~pin_filt_reg[`SADC_PIN_CLK] & clk_prev_reg; // RULE2

  // Read at the format rise, before that bit shifts in: fields still one place low
  always_comb begin
    if (setup_reg[`SADC_ARR_AT_HOLD]) begin
      pick_pos = setup_reg[`SADC_CHAN_AT_HOLD] ? ain1 : ain0; // RULE9 RULE10
      pick_neg = '0;
    end else begin
      pick_pos = setup_reg[`SADC_CHAN_AT_HOLD] ? ain1 : ain0; // RULE5 RULE10
      pick_neg = setup_reg[`SADC_CHAN_AT_HOLD] ? ain0 : ain1;
    end
  end

  // Held at the format bit; a later change of the inputs is not seen
  assign capture = (state_reg == sadc_pkg::ST_SETUP) && clk_rise && cs_act
                 && (setup_cnt_reg == `SADC_SETUP_LAST);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_reg <= '0;
    end else if (capture) begin
      held_reg.pos <= pick_pos; // RULE6
      held_reg.neg <= pick_neg;
    end
  end

  // Unipolar: a negative difference reads as zero
  always_comb begin
    held_diff = (held_reg.pos > held_reg.neg) ? held_reg.pos - held_reg.neg : '0; // RULE5
    scaled = {held_diff, {`SADC_STEP_SH{1'b0}}}; // RULE3
    quot = (vref == '0) ? '1 : scaled / {{`SADC_STEP_SH{1'b0}}, vref};
    if (quot > {{`SADC_IN_W{1'b0}}, `SADC_CODE_MAX}) begin
      code = `SADC_CODE_MAX; // RULE4
    end else begin
      code = quot[`SADC_CODE_W-1:0]; // RULE4
    end
  end

  // Framing state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= sadc_pkg::ST_IDLE;
      setup_cnt_reg <= 2'h0;
      bit_cnt_reg <= 4'h0;
      setup_reg <= '0;
    end else if (!cs_act) begin
      state_reg <= sadc_pkg::ST_IDLE; // RULE1 RULE12
      setup_cnt_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        sadc_pkg::ST_IDLE: begin
          if (clk_rise && din) begin
            state_reg <= sadc_pkg::ST_SETUP; // RULE8
            setup_cnt_reg <= 2'h0;
          end
        end
        sadc_pkg::ST_SETUP: begin
          if (clk_rise) begin
            setup_reg <= {setup_reg[1:0], din}; // RULE8
            setup_cnt_reg <= setup_cnt_reg + 2'h1;
            if (setup_cnt_reg == `SADC_SETUP_LAST) begin
              state_reg <= sadc_pkg::ST_TURN;
            end
          end
        end
        sadc_pkg::ST_TURN: begin
          // Format bit's own fall: host still may drive, so stay off
          if (clk_fall) begin
            state_reg <= sadc_pkg::ST_NULL; // RULE7
          end
        end
        sadc_pkg::ST_NULL: begin
          if (clk_fall) begin
            state_reg <= sadc_pkg::ST_DATA;
            bit_cnt_reg <= `SADC_MSB_IDX;
          end
        end
        sadc_pkg::ST_DATA: begin
          if (clk_fall) begin
            if (bit_cnt_reg == `SADC_LSB_IDX) begin
              state_reg <= sadc_pkg::ST_TAIL;
              bit_cnt_reg <= `SADC_REPEAT_FIRST;
            end else begin
              bit_cnt_reg <= bit_cnt_reg - 4'h1;
            end
          end
        end
        sadc_pkg::ST_TAIL: begin
          if (clk_fall && bit_cnt_reg != `SADC_CNT_TOP) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // Line driver, changes only on shift clock falls and on deselect
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_o_reg <= 1'b0;
      line_oe_reg <= 1'b0;
    end else if (!cs_act) begin
      line_o_reg <= 1'b0;
      line_oe_reg <= 1'b0; // RULE1 RULE12
    end else if (clk_fall) begin
      unique case (state_reg)
        sadc_pkg::ST_NULL: begin
          line_o_reg <= 1'b0; // RULE8
          line_oe_reg <= 1'b1; // RULE7
        end
        sadc_pkg::ST_DATA: begin
          line_o_reg <= code[bit_cnt_reg]; // RULE8
        end
        sadc_pkg::ST_TAIL: begin
          if (setup_reg.tail_zero_bit || bit_cnt_reg > `SADC_MSB_IDX) begin
            line_o_reg <= 1'b0; // RULE11
          end else begin
            line_o_reg <= code[bit_cnt_reg]; // RULE11
          end
        end
        default: begin
          line_o_reg <= line_o_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
      result_reg <= '0;
    end else begin
      busy_reg <= cs_act && (state_reg != sadc_pkg::ST_IDLE);
      if (clk_fall && cs_act && state_reg == sadc_pkg::ST_NULL) begin
        result_reg <= code; // RULE3
      end
    end
  end

  assign shared_serial_line_o = line_o_reg;
  assign shared_serial_line_oe = line_oe_reg;
  assign busy = busy_reg;
  assign result_code = result_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_release_line: assert property (!cs_act |=> !line_oe_reg) // RULE1
    else $error("line driven while deselected");
  a_drive_at_fall: assert property ($rose(line_oe_reg) |-> $past(clk_fall)) // RULE2
    else $error("line drive began off a clock fall");
  a_full_scale: assert property (
    (vref != '0 && held_diff >= vref) |-> code == `SADC_CODE_MAX) // RULE4
    else $error("full scale input not at maximum code");
  a_step_size: assert property (
    (vref != '0 && held_diff < vref) |->
      ({4'h0, code} * vref <= scaled) && ({4'h0, code} * vref + vref > scaled)) // RULE3
    else $error("code not input over reference step");
  a_hold_stable: assert property (
    (state_reg == sadc_pkg::ST_DATA) |-> $stable(held_reg)) // RULE6
    else $error("held level changed during shift out");
  a_null_first: assert property (
    (state_reg == sadc_pkg::ST_NULL && clk_fall && cs_act) |=>
      line_oe_reg && !line_o_reg && state_reg == sadc_pkg::ST_DATA) // RULE8
    else $error("null bit not driven low");
  a_single_ground: assert property (
    (capture && setup_reg[1]) |=> held_reg.neg == '0) // RULE5 RULE9
    else $error("single ended capture kept a negative input");
  a_channel_pick: assert property (
    (capture && setup_reg[1] && setup_reg[0]) |=> held_reg.pos == $past(ain1)) // RULE10
    else $error("second input not captured");
  a_tail_zeros: assert property (
    (state_reg == sadc_pkg::ST_TAIL && setup_reg.tail_zero_bit && clk_fall && cs_act)
      |=> !line_o_reg) // RULE11
    else $error("tail bit not zero");
  a_no_early_drive: assert property (
    (state_reg inside {sadc_pkg::ST_IDLE, sadc_pkg::ST_SETUP, sadc_pkg::ST_TURN})
      |-> ##1 !line_oe_reg) // RULE7
    else $error("line driven before turnaround");
endmodule

// *** hdl/sadc_cfg.svh ***
// Constants of the serial converter readout block
// What this block does
// (RULE1) Serial port acts only while chip select is low; high means idle.
// (RULE2) Host data sampled at clock rise; converter data changes at clock fall.
// (RULE3) Result is a 12-bit unsigned code, one step is reference over 4096.
// (RULE4) Code scales with input over reference; full reference gives 4095.
// (RULE5) Two single-ended inputs or one differential pair are supported.
// (RULE6) Selected input is held when conversion is requested; held value converted.
// (RULE7) Host releases the shared line before the converter starts driving.
// (RULE8) Start bit, three setup bits, then null zero and twelve bits MSB first.
// (RULE9) First setup bit: one single-ended, zero differential.
// (RULE10) Second setup bit picks input, or positive input when differential.
// (RULE11) Third setup bit: one sends zeros after data, zero sends LSB-first repeat.
// (RULE12) Host raises chip select at the end; converter releases line, returns idle.
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
`define SADC_CODE_W 12
`define SADC_IN_W 16
`define SADC_CODE_MAX 12'hfff
`define SADC_STEP_SH 12
`define SADC_SETUP_LAST 2'h2
`define SADC_MSB_IDX 4'hb
`define SADC_LSB_IDX 4'h0
`define SADC_REPEAT_FIRST 4'h1
`define SADC_CNT_TOP 4'hf
`define SADC_PIN_CS 0
`define SADC_PIN_CLK 1
`define SADC_PIN_DAT 2
`define SADC_PIN_IDLE 3'h1
`define SADC_ARR_AT_HOLD 1
`define SADC_CHAN_AT_HOLD 0
`endif

// *** hdl/sadc_pkg.sv ***
// Types shared by the serial converter readout block
package sadc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_TURN,
    ST_NULL,
    ST_DATA,
    ST_TAIL
  } sadc_state_e;

  typedef struct packed {
    logic input_arrangement_bit;
    logic channel_choice_bit;
    logic tail_zero_bit;
  } sadc_setup_s;

  typedef struct packed {
    logic [15:0] pos;
    logic [15:0] neg;
  } sadc_held_s;
endpackage

// *** tb/sadc_host.sv ***
// Host model: select, shift clock and host side of the shared data line
module sadc_host (
  input wire logic line, // Resolved data line
  output logic sel_n, // Chip select, active low
  output logic sck, // Shift clock
  output logic hd, // Host drive value
  output logic hoe, // Host drive enable
  output int pno // Current pulse number
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    hd = 1'b0;
    hoe = 1'b0;
    pno = 0;
  end
  // Samples late in the high phase, well after the device update
  task automatic xfer(input logic [2:0] su, input int n, output logic [31:0] rx);
    rx = '0;
    sel_n = 1'b0;
    hoe = 1'b1;
    #300;
    for (int p = 1; p <= n; p++) begin
      pno = p;
      if (p <= 4) hd = (p == 1) ? 1'b1 : su[4 - p];
      #200 sck = 1'b1;
      #200 rx = {rx[30:0], line};
      sck = 1'b0;
      if (p == 4) hoe = 1'b0;
    end
    #200 sel_n = 1'b1;
    pno = 0;
  endtask
endmodule

// *** tb/sadc_readout_tb.sv ***
// Bench for the serial converter readout block against a host model
module sadc_readout_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dev_o, dev_oe, busy;
  logic line_q = 1'b0;
  logic [15:0] ain0 = '0, ain1 = '0, vref = 16'h1000;
  logic [11:0] result_code;
  wire logic sel_n, sck, hd, hoe;
  int pno, num_errors = 0, cmp_count = 0, cyc = 0, seed = 32'h75aa;
  // Undriven line toggles so a stale level never passes
  wire logic line = dev_oe ? dev_o : (hoe ? hd : ~line_q);
  sadc_host u_host (.line(line), .sel_n(sel_n), .sck(sck), .hd(hd), .hoe(hoe), .pno(pno));
  sadc_readout DUT (.clk(clk), .rst(rst), .sel_n(sel_n), .shift_clk(sck),
    .shared_serial_line_i(line), .shared_serial_line_o(dev_o),
    .shared_serial_line_oe(dev_oe), .ain0(ain0), .ain1(ain1), .vref(vref),
    .busy(busy), .result_code(result_code));
  always #25 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    line_q <= line;
    cyc++;
    if (cyc == 10000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input string nm, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  function automatic logic [11:0] model(input logic s, input logic c);
    int p, q, d;
    p = c ? ain1 : ain0;
    q = s ? 0 : (c ? ain0 : ain1);
    d = (p < q) ? 0 : p - q;
    if (vref == 0) return 12'hfff;
    d = d * 4096 / vref;
    return (d > 4095) ? 12'hfff : d[11:0];
  endfunction
  task automatic run(input logic [2:0] su);
    logic [31:0] rx;
    logic [24:0] ex;
    logic [11:0] cd;
    cd = model(su[2], su[1]);
    ex = {1'b0, cd, 12'h0};
    for (int k = 0; k < 11; k++) ex[11 - k] = su[0] ? 1'b0 : cd[k + 1];
    fork
      u_host.xfer(su, 30, rx);
      begin
        // Well past the hold rise, so the input change cannot race it
        wait (pno == 6);
        @(negedge clk);
        ain0 = 16'($random(seed));
        ain1 = 16'($random(seed));
        check("busy", busy, 1);
      end
    join
    check("stream", rx[24:0], ex);
    check("code", result_code, cd);
    repeat (8) @(negedge clk);
    check("oe idle", dev_oe, 0);
    check("busy idle", busy, 0);
    $display("test setup %b done", su);
  endtask
  initial begin
    logic [31:0] rx;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check("rst oe", dev_oe, 0);
    check("rst code", result_code, 0);
    repeat (4) @(negedge clk);
    // Deselect in mid-result, next frame must start clean
    u_host.xfer(3'b100, 9, rx);
    repeat (8) @(negedge clk);
    check("abort oe", dev_oe, 0);
    $display("test abort done");
    for (int i = 0; i < 8; i++) begin
      ain0 = 16'($random(seed));
      ain1 = 16'($random(seed));
      vref = 16'($random(seed)) | 16'h8000;
      run(i[2:0]);
    end
    vref = 16'd10000;
    ain0 = 16'd10000;
    run(3'b100);
    ain0 = 16'd1000;
    run(3'b100);
    ain0 = 16'd100;
    ain1 = 16'd1000;
    run(3'b000);
    vref = '0;
    run(3'b111);
    tally_and_finish();
  end
endmodule
